// ===== hdl/cais_defines.vh
// Purpose: Shared constants of the CAN interrupt and status control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Offsets are byte addresses
`ifndef CAIS_DEFINES_VH
`define CAIS_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define CAIS_OFS_CTRL     8'h00
`define CAIS_OFS_STATUS   8'h04
`define CAIS_OFS_FLAGS    8'h08
`define CAIS_OFS_FMASK    8'h0C
`define CAIS_OFS_MBMASK   8'h10
`define CAIS_OFS_RXC      8'h14
`define CAIS_OFS_RRQ      8'h18
`define CAIS_OFS_TXP      8'h1C
`define CAIS_OFS_TXC      8'h20
`define CAIS_OFS_TXA      8'h24
`define CAIS_OFS_ABA      8'h28

// ****************************************
// Control bits
// ****************************************
`define CAIS_CTRL_CFG     0
`define CAIS_CTRL_SLEEP   1
`define CAIS_CTRL_WAKE    2
`define CAIS_CTRL_AACK    3
`define CAIS_CTRL_TT      4
`define CAIS_CTRL_DMA     5
`define CAIS_CTRL_RST     6'h01

// ****************************************
// Flag bits and groups
// ****************************************
`define CAIS_F_POR        0
`define CAIS_F_DRX        1
`define CAIS_F_RRX        2
`define CAIS_F_TXW        3
`define CAIS_F_RXW        4
`define CAIS_F_PAS        5
`define CAIS_F_BOFF       6
`define CAIS_F_OVL        7
`define CAIS_F_MBE        8
`define CAIS_F_OVW        9
`define CAIS_F_SLA        12
`define CAIS_F_TOV        13
`define CAIS_F_CMA        14
`define CAIS_F_CMB        15
`define CAIS_FLAGS_RST    16'h0001
`define CAIS_FMASK_RST    16'hFFFF
`define CAIS_MBMASK_RST   32'hFFFFFFFF
`define CAIS_GRP_ERR      16'h0078
`define CAIS_GRP_OVR      16'hF281
`define CAIS_GRP_RM       16'h0006
`define CAIS_GRP_SLE      16'h0100
`define CAIS_FLAGS_USED   16'hF3FF

// ****************************************
// Error counter thresholds
// ****************************************
`define CAIS_LIM_WARN     9'd96
`define CAIS_LIM_PASS     9'd128
`define CAIS_LIM_BOFF     9'd256

`endif

// ===== hdl/cais_err_mon.v
// Purpose: Error counter threshold watch and bus-off recovery count
// Assumes: Counters come from the protocol core, synchronous
// Notes:   Outputs a one-cycle set pulse per crossing
`timescale 1ns/1ps
`include "cais_defines.vh"

module cais_err_mon (
    // Clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    input wire clr_i,
    // Counters from the core
    input wire [8:0] tec_i,
    input wire [8:0] rec_i,
    input wire recessive11_i,
    // Flag set pulses and levels
    output wire txw_set_o,
    output wire rxw_set_o,
    output wire pas_set_o,
    output wire boff_set_o,
    output wire ovl_set_o,
    output wire warn_o,
    output wire boff_o
);
    reg [8:0] boff_cnt_r;
    reg [4:0] prev_r;
    wire boff = (tec_i >= `CAIS_LIM_BOFF);
    wire [8:0] rec_eff = boff ? boff_cnt_r : rec_i;
    wire txw = (tec_i >= `CAIS_LIM_WARN);
    wire rxw = (rec_eff >= `CAIS_LIM_WARN);
    wire pas = ~boff & ((tec_i >= `CAIS_LIM_PASS) |
                        (rec_i >= `CAIS_LIM_PASS));
    wire ovl = boff & (boff_cnt_r >= `CAIS_LIM_PASS);

    assign txw_set_o = txw & ~prev_r[0];                // [RULE3]
    assign rxw_set_o = rxw & ~prev_r[1];                // [RULE3] [RULE14]
    assign pas_set_o = pas & ~prev_r[2];                // [RULE1]
    // Entry and recovery both raise the bus-off flag
    assign boff_set_o = boff ^ prev_r[3];               // [RULE2]
    assign ovl_set_o = ovl & ~prev_r[4];                // [RULE14]
    assign warn_o = txw | rxw;                          // [RULE14]
    assign boff_o = boff;

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            boff_cnt_r <= 9'h000;
            prev_r <= 5'h00;
        end else if (clr_i) begin
            boff_cnt_r <= 9'h000;
            prev_r <= 5'h00;
        end else begin
            prev_r <= {ovl, boff, pas, rxw, txw};
            if (!boff) begin
                boff_cnt_r <= 9'h000;
            end else if (recessive11_i && boff_cnt_r != 9'h1FF) begin
                boff_cnt_r <= boff_cnt_r + 9'h001;      // [RULE14]
            end
        end
    end
endmodule

// ===== hdl/cais_dma_if.v
// Purpose: Transfer controller request for mailbox 0 receptions
// Assumes: Done arrives as a one-cycle pulse
// Notes:   Request stands until done
`timescale 1ns/1ps

module cais_dma_if (
    // Clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    input wire clr_i,
    // Trigger and transfer controller
    input wire trig_i,
    input wire done_i,
    output wire req_o,
    output wire clear_o
);
    reg req_r;

    assign req_o = req_r;
    assign clear_o = req_r & done_i;                    // [RULE7]

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_r <= 1'b0;
        end else if (clr_i) begin
            req_r <= 1'b0;
        end else if (trig_i) begin
            req_r <= 1'b1;                              // [RULE7]
        end else if (done_i) begin
            req_r <= 1'b0;
        end
    end
endmodule

// ===== hdl/cais_top.v
// Purpose: Interrupt, status, transmit control and sleep of a CAN node
// Assumes: Core events are one-cycle pulses, synchronous to ref_clk_i
// Notes:   Mailbox storage lives outside; halfword APB writes only
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "cais_defines.vh"

// Behaviour
// RULE1 - Error passive flag when either error counter is 128 or more.
// RULE2 - Bus-off flag at transmit count 256, also on recovery.
// RULE3 - Transmit and receive warning flags at count 96.
// RULE4 - Overload, overwrite, sleep activity on general line, no transfer.
// RULE5 - Timer overflow and two compare flags on general line.
// RULE6 - Every flag maskable except the power-on reset flag.
// RULE7 - Mailbox 0 reception triggers transfer; done clears its bits.
// RULE8 - Mailbox 0 receive interrupt withheld while transfers service it.
// RULE9 - Software keeps the timer stopped in event-triggered mode.
// RULE10 - Resets and standby initialise registers, not mailbox storage.
// RULE11 - Reset flag set after power-on or standby; software clears.
// RULE12 - Bus activity in sleep sets flag; reset status reads set.
// RULE13 - Masked mailboxes never set empty or receive flags.
// RULE14 - In bus-off count 11-bit recessive runs; 96 warns, 128 overload.
// RULE15 - Word accesses only, never longword.
// RULE16 - Late cancel still sends, acknowledges, clears and aborts.
// RULE17 - Software sets pending bits together, outside end of frame.
// RULE18 - Software touches the filter mask only in configuration.
// RULE19 - Auto-acknowledge test transmits but drops own reception.
// RULE20 - Mailbox 31 cannot be cancelled under event trigger.
// RULE21 - Software waits over 50 us before cancelling in bus idle.
// RULE22 - Software checks reset status before leaving configuration.
// RULE23 - Sleep request enters sleep once the bus is idle.
// RULE24 - Each line is high while any unmasked flag of its group is set.
module cais_top (
    // Clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    input wire hw_standby_i,
    input wire sw_standby_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire pready_o,
    output wire pslverr_o,
    output wire [31:0] prdata_o,
    // Protocol core events
    input wire [8:0] tec_i,
    input wire [8:0] rec_i,
    input wire recessive11_i,
    input wire bus_idle_i,
    input wire bus_activity_i,
    input wire overload_sent_i,
    input wire overwrite_i,
    input wire rx_done_i,
    input wire [4:0] rx_mb_i,
    input wire rx_remote_i,
    input wire rx_own_i,
    input wire tx_busy_i,
    input wire [4:0] tx_mb_i,
    input wire tx_done_i,
    input wire sof_inter_i,
    // Timestamp timer events
    input wire timer_overflow_i,
    input wire timer_compare_a_i,
    input wire timer_compare_b_i,
    // Control towards the core
    output wire [31:0] tx_pending_bits_o,
    output wire config_reset_o,
    output wire sleep_o,
    output wire auto_acknowledge_test_o,
    output wire time_trigger_select_o,
    // Transfer controller
    output wire dma_req_o,
    input wire dma_done_i,
    // Interrupt request lines
    output wire error_irq_line_o,
    output wire overrun_general_irq_line_o,
    output wire receive_irq_line_o,
    output wire mailbox_empty_irq_line_o
);

    // ****************************************
    // States and helpers
    // ****************************************
    localparam ST_AWAKE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_ASLEEP = 2'd2;

    function [31:0] onehot;
        input [4:0] mb;
        begin
            onehot = 32'h00000001 << mb;
        end
    endfunction

    function [31:0] lanes;
        input [3:0] strb;
        begin
            lanes = {{16{strb[2]}}, {16{strb[0]}}};
        end
    endfunction

    reg [5:0] ctrl_r, ctrl_nxt;
    reg [15:0] flag_r, flag_nxt;
    reg [15:0] fmask_r, fmask_nxt;
    reg [31:0] mbmask_r, mbmask_nxt, rxc_r, rxc_nxt;
    reg [31:0] rrq_r, rrq_nxt, txp_r, txp_nxt, txc_r, txc_nxt;
    reg [31:0] txa_r, txa_nxt, aba_r, aba_nxt;
    reg [1:0] state_r, state_nxt;
    reg [31:0] rdata_r, rdata_nxt;

    wire stby = hw_standby_i | sw_standby_i;           // [RULE10]

    // ****************************************
    // Bus decode
    // ****************************************
    // Registers sit on every aligned word up to the last offset
    wire mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= `CAIS_OFS_ABA);
    // Halfword lanes only; a full word would be a longword access
    wire strb_ok = (pstrb_i == 4'h3) || (pstrb_i == 4'hC); // [RULE15]
    wire access = psel_i & penable_i;
    wire bad = ~mapped | (pwrite_i & ~strb_ok);
    wire wr = access & pwrite_i & ~bad;
    wire [31:0] wbits = pwdata_i & lanes(pstrb_i);
    wire [31:0] wkeep = ~lanes(pstrb_i);

    assign pready_o = 1'b1;
    assign pslverr_o = access & bad;
    assign prdata_o = rdata_r;

    // ****************************************
    // Sub-blocks
    // ****************************************
    wire txw_set, rxw_set, pas_set, boff_set, ovl_set, warn, boff;
    wire dma_clear;

    cais_err_mon u_err (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .clr_i(stby),
        .tec_i(tec_i),
        .rec_i(rec_i),
        .recessive11_i(recessive11_i),
        .txw_set_o(txw_set),
        .rxw_set_o(rxw_set),
        .pas_set_o(pas_set),
        .boff_set_o(boff_set),
        .ovl_set_o(ovl_set),
        .warn_o(warn),
        .boff_o(boff)
    );

    wire dma_en = ctrl_r[`CAIS_CTRL_DMA];
    wire aack = ctrl_r[`CAIS_CTRL_AACK];
    // Own frames are dropped in auto-acknowledge test
    wire rx_ok = rx_done_i & ~(aack & rx_own_i);        // [RULE19]
    wire rx_mb0 = (rx_mb_i == 5'd0);
    wire dma_trig = rx_ok & rx_mb0 & dma_en;            // [RULE7]
    wire [31:0] rx_hot = onehot(rx_mb_i);
    wire rx_masked = |(rx_hot & mbmask_r);
    wire rx_flag_ok = ~rx_masked & ~(dma_en & rx_mb0);  // [RULE8] [RULE13]

    cais_dma_if u_dma (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .clr_i(stby),
        .trig_i(dma_trig),
        .done_i(dma_done_i),
        .req_o(dma_req_o),
        .clear_o(dma_clear)
    );

    // ****************************************
    // Outputs to the core and interrupt lines
    // ****************************************
    wire asleep = (state_r == ST_ASLEEP);
    wire [15:0] pend = flag_r & ~{fmask_r[15:1], 1'b0}; // [RULE6]

    assign error_irq_line_o = |(pend & `CAIS_GRP_ERR);   // [RULE24]
    assign overrun_general_irq_line_o =
        |(pend & `CAIS_GRP_OVR);                        // [RULE4] [RULE5]
    assign receive_irq_line_o = |(pend & `CAIS_GRP_RM);  // [RULE24]
    assign mailbox_empty_irq_line_o =
        |(pend & `CAIS_GRP_SLE);                        // [RULE24]
    assign tx_pending_bits_o = txp_r;
    assign config_reset_o = ctrl_r[`CAIS_CTRL_CFG];
    assign sleep_o = asleep;
    assign auto_acknowledge_test_o = aack;
    assign time_trigger_select_o = ctrl_r[`CAIS_CTRL_TT];

    // ****************************************
    // Next-state logic
    // ****************************************
    reg [15:0] fset, fclr;
    reg [31:0] cancel, in_flight, tx_hot, now_abort, ack_set;
    reg [31:0] c31, mbe_src;
    always @* begin
        fset = 16'h0000;
        tx_hot = onehot(tx_mb_i);
        ctrl_nxt = ctrl_r;
        fmask_nxt = fmask_r;
        mbmask_nxt = mbmask_r;
        state_nxt = state_r;
        rdata_nxt = rdata_r;

        // Plain register writes
        if (wr && paddr_i == `CAIS_OFS_CTRL) begin
            ctrl_nxt = (ctrl_r & wkeep[5:0]) | wbits[5:0];
        end
        if (wr && paddr_i == `CAIS_OFS_FMASK) begin
            fmask_nxt = (fmask_r & wkeep[15:0]) | wbits[15:0];
        end
        if (wr && paddr_i == `CAIS_OFS_MBMASK) begin
            mbmask_nxt = (mbmask_r & wkeep) | wbits;
        end

        // Sleep control
        case (state_r)
            ST_AWAKE: begin
                if (ctrl_r[`CAIS_CTRL_SLEEP]) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!ctrl_r[`CAIS_CTRL_SLEEP]) begin
                    state_nxt = ST_AWAKE;
                end else if (bus_idle_i) begin
                    state_nxt = ST_ASLEEP;              // [RULE23]
                end
            end
            ST_ASLEEP: begin
                if (!ctrl_r[`CAIS_CTRL_SLEEP]) begin
                    state_nxt = ST_AWAKE;
                end else if (bus_activity_i &&
                             ctrl_r[`CAIS_CTRL_WAKE]) begin
                    state_nxt = ST_AWAKE;
                    ctrl_nxt[`CAIS_CTRL_SLEEP] = 1'b0;
                end
            end
            default: begin
                state_nxt = ST_AWAKE;
            end
        endcase

        // Transmit cancel and completion
        in_flight = tx_hot & {32{tx_busy_i}};
        c31 = {~ctrl_r[`CAIS_CTRL_TT], 31'h00000000};   // [RULE20]
        cancel = wbits & txp_r & ~c31 &
                 {32{wr && paddr_i == `CAIS_OFS_TXC}};
        // A frame already on the wire keeps its cancel until it ends
        now_abort = cancel & ~in_flight;
        ack_set = tx_hot & {32{tx_done_i}};
        txc_nxt = (txc_r | (cancel & in_flight)) & ~ack_set;
        aba_nxt = aba_r | now_abort |
                  (ack_set & txc_r);                    // [RULE16]
        txa_nxt = txa_r | ack_set;                      // [RULE16]
        txp_nxt = txp_r & ~now_abort & ~ack_set;        // [RULE16]
        if (wr && paddr_i == `CAIS_OFS_TXP) begin
            txp_nxt = txp_nxt | wbits;
        end
        if (wr && paddr_i == `CAIS_OFS_TXA) begin
            txa_nxt = txa_nxt & ~(wbits & ~ack_set);
        end
        if (wr && paddr_i == `CAIS_OFS_ABA) begin
            aba_nxt = aba_nxt & ~(wbits & ~now_abort &
                                  ~(ack_set & txc_r));
        end
        mbe_src = (ack_set | now_abort) & ~mbmask_r;    // [RULE13]

        // Reception bits, set wins over clear
        rxc_nxt = rxc_r & ~{31'h00000000, dma_clear};   // [RULE7]
        rrq_nxt = rrq_r & ~{31'h00000000, dma_clear};   // [RULE7]
        if (wr && paddr_i == `CAIS_OFS_RXC) begin
            rxc_nxt = rxc_nxt & ~wbits;
        end
        if (wr && paddr_i == `CAIS_OFS_RRQ) begin
            rrq_nxt = rrq_nxt & ~wbits;
        end
        rxc_nxt = rxc_nxt | (rx_hot & {32{rx_ok & ~rx_remote_i}});
        rrq_nxt = rrq_nxt | (rx_hot & {32{rx_ok & rx_remote_i}});

        // Flag sources
        fset[`CAIS_F_DRX] = rx_ok & ~rx_remote_i & rx_flag_ok;
        fset[`CAIS_F_RRX] = rx_ok & rx_remote_i & rx_flag_ok;
        fset[`CAIS_F_TXW] = txw_set;                    // [RULE3]
        fset[`CAIS_F_RXW] = rxw_set;                    // [RULE3]
        fset[`CAIS_F_PAS] = pas_set;                    // [RULE1]
        fset[`CAIS_F_BOFF] = boff_set;                  // [RULE2]
        fset[`CAIS_F_OVL] = overload_sent_i | ovl_set;  // [RULE4]
        fset[`CAIS_F_MBE] = |mbe_src;                   // [RULE13]
        fset[`CAIS_F_OVW] = overwrite_i;                // [RULE4]
        fset[`CAIS_F_SLA] = asleep & bus_activity_i;    // [RULE12]
        fset[`CAIS_F_TOV] = timer_overflow_i;           // [RULE5]
        fset[`CAIS_F_CMA] = timer_compare_a_i;          // [RULE5]
        fset[`CAIS_F_CMB] = timer_compare_b_i;          // [RULE5]
        fclr = wbits[15:0] & {16{wr && paddr_i == `CAIS_OFS_FLAGS}};
        flag_nxt = ((flag_r & ~fclr) | fset) & `CAIS_FLAGS_USED;

        // Read data is captured in the setup phase
        if (psel_i && !penable_i && !pwrite_i) begin
            if (paddr_i == `CAIS_OFS_CTRL) begin
                rdata_nxt = {26'h0000000, ctrl_r};
            end else if (paddr_i == `CAIS_OFS_STATUS) begin
                rdata_nxt = {28'h0000000, boff, asleep, warn,
                             asleep | ctrl_r[`CAIS_CTRL_CFG]}; // [RULE12]
            end else if (paddr_i == `CAIS_OFS_FLAGS) begin
                rdata_nxt = {16'h0000, flag_r};
            end else if (paddr_i == `CAIS_OFS_FMASK) begin
                rdata_nxt = {16'h0000, fmask_r};
            end else if (paddr_i == `CAIS_OFS_MBMASK) begin
                rdata_nxt = mbmask_r;
            end else if (paddr_i == `CAIS_OFS_RXC) begin
                rdata_nxt = rxc_r;
            end else if (paddr_i == `CAIS_OFS_RRQ) begin
                rdata_nxt = rrq_r;
            end else if (paddr_i == `CAIS_OFS_TXP) begin
                rdata_nxt = txp_r;
            end else if (paddr_i == `CAIS_OFS_TXC) begin
                rdata_nxt = txc_r;
            end else if (paddr_i == `CAIS_OFS_TXA) begin
                rdata_nxt = txa_r;
            end else if (paddr_i == `CAIS_OFS_ABA) begin
                rdata_nxt = aba_r;
            end else begin
                rdata_nxt = 32'h00000000;
            end
        end
    end

    // ****************************************
    // State registers
    // ****************************************
    // Standby acts like reset and leaves the reset flag raised
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= `CAIS_CTRL_RST;
            flag_r <= `CAIS_FLAGS_RST;                  // [RULE11]
            fmask_r <= `CAIS_FMASK_RST;
            mbmask_r <= `CAIS_MBMASK_RST;
            rxc_r <= 32'h00000000;
            rrq_r <= 32'h00000000;
            txp_r <= 32'h00000000;
            txc_r <= 32'h00000000;
            txa_r <= 32'h00000000;
            aba_r <= 32'h00000000;
            state_r <= ST_AWAKE;
            rdata_r <= 32'h00000000;
        end else if (stby) begin
            ctrl_r <= `CAIS_CTRL_RST;                   // [RULE10]
            flag_r <= `CAIS_FLAGS_RST;                  // [RULE11]
            fmask_r <= `CAIS_FMASK_RST;
            mbmask_r <= `CAIS_MBMASK_RST;
            rxc_r <= 32'h00000000;
            rrq_r <= 32'h00000000;
            txp_r <= 32'h00000000;
            txc_r <= 32'h00000000;
            txa_r <= 32'h00000000;
            aba_r <= 32'h00000000;
            state_r <= ST_AWAKE;
            rdata_r <= 32'h00000000;
        end else begin
            ctrl_r <= ctrl_nxt;
            flag_r <= flag_nxt;
            fmask_r <= fmask_nxt;
            mbmask_r <= mbmask_nxt;
            rxc_r <= rxc_nxt;
            rrq_r <= rrq_nxt;
            txp_r <= txp_nxt;
            txc_r <= txc_nxt;
            txa_r <= txa_nxt;
            aba_r <= aba_nxt;
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
        end
    end
endmodule

// ===== tb/cais_sva.sv
// Purpose: Port assertions for the interrupt block
// Assumes: One clock, reset async active low
// Notes: Masks are internal, so line checks lean on writes
`timescale 1ns/1ps
module cais_sva (
    input wire ref_clk_i, resetn_i, hw_standby_i, sw_standby_i,
    input wire psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
    input wire [3:0] pstrb_i,
    input wire [7:0] paddr_i,
    input wire [31:0] prdata_o, tx_pending_bits_o,
    input wire rx_done_i, rx_own_i, bus_idle_i, dma_done_i, dma_req_o,
    input wire [4:0] rx_mb_i,
    input wire config_reset_o, sleep_o, auto_acknowledge_test_o,
    input wire error_irq_line_o, overrun_general_irq_line_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_RST: assert property (
        $rose(resetn_i) |-> config_reset_o && overrun_general_irq_line_o
        && !dma_req_o && tx_pending_bits_o == 32'h0)
        else $error("reset values wrong");
    AST_READY: assert property (pready_o) else $error("no ready");
    AST_LONG: assert property (
        psel_i && penable_i && pwrite_i && pstrb_i == 4'hF |-> pslverr_o)
        else $error("longword write accepted");
    AST_ERR_FALL: assert property (
        $fell(error_irq_line_o) |-> $past(psel_i && penable_i && pwrite_i)
        || $past(hw_standby_i || sw_standby_i))
        else $error("error line fell without a write");
    AST_DMA_SRC: assert property (
        $rose(dma_req_o) |-> $past(rx_done_i && rx_mb_i == 5'h0
        && !(rx_own_i && auto_acknowledge_test_o)))
        else $error("transfer request without mailbox 0 reception");
    AST_DMA_HOLD: assert property (
        dma_req_o && !dma_done_i && !hw_standby_i && !sw_standby_i
        |=> dma_req_o) else $error("transfer request dropped");
    AST_DMA_DONE: assert property (
        dma_req_o && dma_done_i && !rx_done_i |=> !dma_req_o)
        else $error("transfer request stuck after done");
    AST_SLEEP: assert property (
        $rose(sleep_o) |-> $past(bus_idle_i))
        else $error("sleep entered on busy bus");
    AST_RSTAT: assert property (
        psel_i && !penable_i && !pwrite_i && paddr_i == 8'h04 && sleep_o
        |=> prdata_o[0]) else $error("reset status clear in sleep");
endmodule
bind cais_top cais_sva chk_i (.*);

// ===== tb/cais_core_model.sv
// Purpose: Protocol core and timer stand-in for the interrupt block
// Assumes: Events are one-cycle pulses launched after a rising edge
// Notes: Transmit path stays quiet; only receive, counters and bus state move
`timescale 1ns/1ps
module cais_core_model (
    input wire ref_clk_i,
    output logic [8:0] tec_i, rec_i,
    output logic [4:0] rx_mb_i, tx_mb_i,
    output logic recessive11_i, bus_idle_i, bus_activity_i, rx_done_i,
    output logic overload_sent_i, overwrite_i, rx_remote_i, rx_own_i,
    output logic tx_busy_i, tx_done_i, sof_inter_i, timer_overflow_i,
    output logic timer_compare_a_i, timer_compare_b_i
);
    // Timer stays stopped throughout; overflow and compare outputs never pulse
    initial begin
        {tec_i, rec_i, rx_mb_i, tx_mb_i, recessive11_i, bus_idle_i} = '0;
        {bus_activity_i, rx_done_i, overload_sent_i, overwrite_i} = '0;
        {rx_remote_i, rx_own_i, tx_busy_i, tx_done_i, sof_inter_i} = '0;
        {timer_overflow_i, timer_compare_a_i, timer_compare_b_i} = '0;
    end
    task cnt(input [8:0] t, input [8:0] r);
        @(posedge ref_clk_i);
        tec_i <= t;
        rec_i <= r;
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask
    task rx(input [4:0] mb);
        @(posedge ref_clk_i);
        rx_done_i <= 1'b1;
        rx_mb_i <= mb;
        @(posedge ref_clk_i);
        rx_done_i <= 1'b0;
        #1;
    endtask
    task r11;
        @(posedge ref_clk_i);
        recessive11_i <= 1'b1;
        @(posedge ref_clk_i);
        recessive11_i <= 1'b0;
        #1;
    endtask
    task bus(input idle, input act);
        @(posedge ref_clk_i);
        bus_idle_i <= idle;
        bus_activity_i <= act;
        @(posedge ref_clk_i);
        bus_activity_i <= 1'b0;
        #1;
    endtask
endmodule

// ===== tb/cais_top_tb.sv
// Purpose: Self-checking bench of the interrupt block
// Assumes: APB slave with zero wait states still waits on pready
// Notes: Checks settle one ns after the edge that causes them
`timescale 1ns/1ps
module cais_top_tb;
    logic ref_clk_i, resetn_i, hw_standby_i, sw_standby_i, dma_done_i;
    logic psel_i, penable_i, pwrite_i, err;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, rd;
    logic [3:0] pstrb_i;
    wire pready_o, pslverr_o, config_reset_o, sleep_o, dma_req_o;
    wire auto_acknowledge_test_o, time_trigger_select_o, error_irq_line_o;
    wire overrun_general_irq_line_o, receive_irq_line_o;
    wire mailbox_empty_irq_line_o;
    wire [31:0] prdata_o, tx_pending_bits_o;
    wire [8:0] tec_i, rec_i;
    wire [4:0] rx_mb_i, tx_mb_i;
    wire recessive11_i, bus_idle_i, bus_activity_i, rx_done_i, rx_own_i;
    wire overload_sent_i, overwrite_i, rx_remote_i, tx_busy_i, tx_done_i;
    wire sof_inter_i, timer_overflow_i, timer_compare_a_i;
    wire timer_compare_b_i;
    int n_errors, checks;
    cais_top uut (.*);
    cais_core_model core (.*);
    task chk(input string n, input [31:0] e, input [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d, input [3:0] s);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        @(posedge ref_clk_i);
        while (pready_o !== 1'b1) @(posedge ref_clk_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        #1;
    endtask
    task t_reset;
        chk("por line", 1, overrun_general_irq_line_o);
        apb(0, 8'h08, 0, 4'h0);
        chk("flags", 32'h1, rd);
        apb(1, 8'h0C, 0, 4'h3);
        apb(1, 8'h08, 1, 4'h3);
        chk("por clear", 0, overrun_general_irq_line_o);
    endtask
    task t_err;
        core.cnt(9'd96, 0);
        chk("warn line", 1, error_irq_line_o);
        core.cnt(9'd128, 0);
        core.cnt(9'h100, 0);
        apb(0, 8'h08, 0, 4'h0);
        chk("err flags", 32'h68, rd);
        apb(1, 8'h08, 32'h78, 4'h3);
        chk("err clear", 0, error_irq_line_o);
        repeat (128) core.r11;
        apb(0, 8'h08, 0, 4'h0);
        chk("busoff flags", 32'h90, rd);
        core.cnt(0, 0);
        apb(1, 8'h08, 32'hFFFF, 4'h3);
    endtask
    // Pending, cancel and filter mask stay untouched
    task t_dma;
        apb(0, 8'h04, 0, 4'h0);
        chk("cfg status", 1, rd[0]);
        apb(1, 8'h00, 32'h20, 4'h3);
        apb(1, 8'h10, 0, 4'h3);
        core.rx(0);
        chk("dma req", 1, dma_req_o);
        chk("rx line dma", 0, receive_irq_line_o);
        @(posedge ref_clk_i) dma_done_i <= 1'b1;
        @(posedge ref_clk_i) dma_done_i <= 1'b0;
        apb(0, 8'h14, 0, 4'h0);
        chk("rx complete", 0, rd);
        core.rx(1);
        chk("rx line", 1, receive_irq_line_o);
        apb(1, 8'h08, 2, 4'h3);
        core.rx(20);
        chk("masked mb", 0, receive_irq_line_o);
    endtask
    task t_sleep;
        apb(1, 8'h00, 32'h22, 4'h3);
        chk("sleep busy", 0, sleep_o);
        core.bus(1, 0);
        chk("asleep", 1, sleep_o);
        apb(0, 8'h04, 0, 4'h0);
        chk("reset status", 1, rd[0]);
        core.bus(1, 1);
        chk("activity line", 1, overrun_general_irq_line_o);
        chk("still asleep", 1, sleep_o);
    endtask
    task t_bad;
        apb(1, 8'h00, 0, 4'hF);
        chk("long err", 1, err);
        apb(0, 8'h40, 0, 4'h0);
        chk("unmapped", 1, {rd[0], err});
        apb(0, 8'h00, 0, 4'h0);
        chk("ctrl kept", 32'h22, rd);
    endtask
    task summarize;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        ref_clk_i = 0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        n_errors++;
        summarize;
    end
    initial begin
        {resetn_i, hw_standby_i, sw_standby_i, dma_done_i} = '0;
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = '0;
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        t_reset;
        t_err;
        t_dma;
        t_sleep;
        t_bad;
        summarize;
    end
endmodule
